//--- rtl/can_acceptance_filter_fifo_ctrl.sv
// Acceptance filtering, FIFO routing and FIFO transmit control over APB
//
// Summary of operation
// - Set standard mask bit includes that identifier bit in comparison.
// - Set extended mask bit includes that identifier bit in comparison.
// - Type match bit set demands frame type equal filter's extended flag.
// - Mask registers take writes only in configuration operating mode.
// - Unused mask bits, including 20 and 18, read as zero.
// - Five-bit FIFO select routes a passing message to FIFO 0-15.
// - FIFO selects sit at bits 4-0, 12-8 and 20-16.
// - Enable bits 7, 15 and 23; a disabled filter accepts nothing.
// - Two-bit mask select picks mask 0-3, at bits 6-5, 14-13 and 22-21.
// - Mask and FIFO selects writable only while filter disabled.
// - FIFO control bit 7 chooses transmit (1) or receive (0).
// - Bit 6 shows whether the last message aborted or completed.
// - Bit 5 sets when a message lost arbitration.
// - Bit 4 sets when a bus error hit a sent message.
// - Software sets send request; device clears it; software clear aborts.
// - Send request has no effect on a receive FIFO.
// - Abort bit updates only on completion, abort or FIFO reset.
// - Arbitration and error bits clear on read and FIFO reset.
`timescale 1ns/1ps
`default_nettype none
module can_acceptance_filter_fifo_ctrl #(
    parameter int NUM_FIFOS = 16,
    parameter int NUM_MASKS = 4,
    parameter int NUM_FILTERS = 3
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [can_filt_pkg::ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_msg_valid,
    input wire can_filt_pkg::can_id_type rx_msg,
    input wire can_filt_pkg::tx_event_type tx_event,
    output can_filt_pkg::rx_route_type rx_route,
    output logic [2:0] operating_mode_field,
    output logic [NUM_FIFOS-1:0] fifo_direction,
    output logic [NUM_FIFOS-1:0] send_request,
    output logic [NUM_FIFOS-1:0] abort_request
);
    // ==========================================================
    // Elaboration checks
    // Field packing and index widths only serve these ranges
    if (NUM_FIFOS < 1 || NUM_FIFOS > 16) begin : bad_fifos
        $error("NUM_FIFOS must be 1 to 16");
    end

    if (NUM_MASKS != 4) begin : bad_masks
        $error("NUM_MASKS must be 4");
    end

    if (NUM_FILTERS < 1 || NUM_FILTERS > 3) begin : bad_filters
        $error("NUM_FILTERS must be 1 to 3");
    end

    // ==========================================================
    // Register state
    logic [31:0] acceptance_mask_reg [NUM_MASKS];
    logic [31:0] filter_id_reg [NUM_FILTERS];
    logic [23:0] filter_control_reg0;

    // Next values
    logic [31:0] next_acceptance_mask_reg [NUM_MASKS];
    logic [31:0] next_filter_id_reg [NUM_FILTERS];
    logic [23:0] next_filter_control_reg0;
    logic [2:0] next_operating_mode_field;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    // Decode and handshake
    logic config_mode;
    logic setup_done;
    logic access_done;
    logic is_mask;
    logic is_filter_id;
    logic is_fifo;
    logic mapped;
    logic [1:0] reg_index;
    logic [3:0] fifo_index;

    // Per-FIFO taps
    logic [7:0] fifo_status [NUM_FIFOS];
    logic [NUM_FIFOS-1:0] fifo_write;
    logic [NUM_FIFOS-1:0] fifo_read;

    assign config_mode = (operating_mode_field == can_filt_pkg::CONFIG_MODE);

    // Answer comes one cycle into the access phase
    assign setup_done = psel && penable && !pready;
    assign access_done = psel && penable && pready;

    // ==========================================================
    // Address decode
    // Word index per region
    assign reg_index = paddr[3:2];
    assign fifo_index = paddr[5:2];
    assign is_mask = (paddr[7:4] == can_filt_pkg::MASK_REGION);
    assign is_filter_id = (paddr[7:4] == can_filt_pkg::FILTER_ID_REGION) &&
        (int'(reg_index) < NUM_FILTERS);
    assign is_fifo = (paddr[7:6] == can_filt_pkg::FIFO_REGION) &&
        (int'(fifo_index) < NUM_FIFOS);
    assign mapped = (paddr[1:0] == can_filt_pkg::WORD_ALIGNED) &&
        (is_mask || is_filter_id || is_fifo ||
        paddr == can_filt_pkg::FILTER_CTRL0_ADDR ||
        paddr == can_filt_pkg::CONTROLLER_CTRL_ADDR);

    // ==========================================================
    // APB answer
    always_comb begin
        next_pready = setup_done;
        // Unmapped or misaligned
        next_pslverr = setup_done && !mapped;
        next_prdata = 32'h0000_0000;

        // Zero unless a mapped read
        if (setup_done && !pwrite && mapped) begin
            if (is_mask) begin
                next_prdata = acceptance_mask_reg[reg_index] &
                    can_filt_pkg::MASK_USED_BITS;
            end else if (is_filter_id) begin
                next_prdata = filter_id_reg[reg_index] &
                    can_filt_pkg::MASK_USED_BITS;
            end else if (is_fifo) begin
                next_prdata = {24'h00_0000, fifo_status[fifo_index]};
            end else if (paddr == can_filt_pkg::FILTER_CTRL0_ADDR) begin
                next_prdata = {8'h00, filter_control_reg0};
            end else begin
                next_prdata[can_filt_pkg::OPMODE_MSB:can_filt_pkg::OPMODE_LSB] =
                    operating_mode_field;
            end
        end
    end

    // Registered answer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ==========================================================
    // Register writes
    always_comb begin
        next_acceptance_mask_reg = acceptance_mask_reg;
        next_filter_id_reg = filter_id_reg;
        next_filter_control_reg0 = filter_control_reg0;
        next_operating_mode_field = operating_mode_field;

        if (access_done && pwrite && mapped) begin
            if (is_mask && config_mode) begin
                next_acceptance_mask_reg[reg_index] = pwdata &
                    can_filt_pkg::MASK_USED_BITS;
            end

            // Writable in any mode
            if (is_filter_id) begin
                next_filter_id_reg[reg_index] = pwdata &
                    can_filt_pkg::MASK_USED_BITS;
            end

            if (paddr == can_filt_pkg::CONTROLLER_CTRL_ADDR) begin
                next_operating_mode_field =
                    pwdata[can_filt_pkg::OPMODE_MSB:can_filt_pkg::OPMODE_LSB];
            end

            if (paddr == can_filt_pkg::FILTER_CTRL0_ADDR) begin
                for (int f = 0; f < NUM_FILTERS; f++) begin
                    next_filter_control_reg0[f * can_filt_pkg::FILTER_STRIDE +
                        can_filt_pkg::FILTER_EN_BIT] =
                        pwdata[f * can_filt_pkg::FILTER_STRIDE +
                        can_filt_pkg::FILTER_EN_BIT];

                    if (!filter_control_reg0[f * can_filt_pkg::FILTER_STRIDE +
                        can_filt_pkg::FILTER_EN_BIT]) begin
                        next_filter_control_reg0[f *
                            can_filt_pkg::FILTER_STRIDE +:
                            can_filt_pkg::FILTER_EN_BIT] =
                            pwdata[f * can_filt_pkg::FILTER_STRIDE +:
                            can_filt_pkg::FILTER_EN_BIT];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int m = 0; m < NUM_MASKS; m++) begin
                acceptance_mask_reg[m] <= can_filt_pkg::MASK_RESET;
            end
            for (int f = 0; f < NUM_FILTERS; f++) begin
                filter_id_reg[f] <= can_filt_pkg::MASK_RESET;
            end

            // Filters off, mode zero
            filter_control_reg0 <= can_filt_pkg::FILTER_CTRL_RESET;
            operating_mode_field <= 3'h0;
        end else begin
            acceptance_mask_reg <= next_acceptance_mask_reg;
            filter_id_reg <= next_filter_id_reg;
            filter_control_reg0 <= next_filter_control_reg0;
            operating_mode_field <= next_operating_mode_field;
        end
    end

    // ==========================================================
    // Acceptance filters
    logic [NUM_FILTERS-1:0] filter_hit;
    logic [4:0] filter_fsel [NUM_FILTERS];
    can_filt_pkg::rx_route_type next_rx_route;

    // Masks shared, picked by code

    for (genvar g = 0; g < NUM_FILTERS; g++) begin : filters
        // One control byte per filter
        logic [1:0] mask_select;

        assign mask_select = filter_control_reg0[g *
            can_filt_pkg::FILTER_STRIDE + can_filt_pkg::MSEL_LSB +: 2];
        assign filter_fsel[g] = filter_control_reg0[g *
            can_filt_pkg::FILTER_STRIDE + can_filt_pkg::FSEL_LSB +:
            can_filt_pkg::FSEL_WIDTH];
        can_filter_match match (
            .msg(rx_msg),
            .filter_id(filter_id_reg[g]),
            .mask(acceptance_mask_reg[mask_select]),
            .enable(filter_control_reg0[g * can_filt_pkg::FILTER_STRIDE +
                can_filt_pkg::FILTER_EN_BIT]),
            .hit(filter_hit[g])
        );
    end

    always_comb begin
        next_rx_route = '0;

        // lowest filter wins
        // Walk downward so the lowest hit overwrites the rest
        for (int f = NUM_FILTERS - 1; f >= 0; f--) begin
            if (rx_msg_valid && filter_hit[f]) begin
                next_rx_route.valid = !filter_fsel[f][4] &&
                    (int'(filter_fsel[f][3:0]) < NUM_FIFOS);
                next_rx_route.fifo = filter_fsel[f][3:0];
                next_rx_route.filter = 2'(f);
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_route <= '0;
        end else begin
            rx_route <= next_rx_route;
        end
    end

    // ==========================================================
    // FIFO control
    // Read side effects happen when read data is captured, so no event
    // can land between the sampled value and the clear
    for (genvar q = 0; q < NUM_FIFOS; q++) begin : fifos
        // Strobes for this FIFO
        assign fifo_write[q] = access_done && pwrite && mapped && is_fifo &&
            (int'(fifo_index) == q);
        assign fifo_read[q] = setup_done && !pwrite && mapped && is_fifo &&
            (int'(fifo_index) == q);

        can_fifo_ctrl ctrl (
            .clk(clk),
            .sys_rst(sys_rst),
            .config_mode(config_mode),
            .write_en(fifo_write[q]),
            .wdata(pwdata),
            .read_en(fifo_read[q]),
            .event_here(tx_event.valid && (int'(tx_event.fifo) == q)),
            .tx_event(tx_event),
            .status(fifo_status[q]),
            .direction(fifo_direction[q]),
            .send_request(send_request[q]),
            .abort_request(abort_request[q])
        );
    end
endmodule : can_acceptance_filter_fifo_ctrl
`default_nettype wire

//--- rtl/can_fifo_ctrl.sv
// Control and transmit status of one message FIFO
`timescale 1ns/1ps
`default_nettype none
module can_fifo_ctrl (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic config_mode,
    input wire logic write_en,
    input wire logic [31:0] wdata,
    input wire logic read_en,
    input wire logic event_here,
    input wire can_filt_pkg::tx_event_type tx_event,
    output logic [7:0] status,
    output logic direction,
    output logic send_request,
    output logic abort_request
);
    logic aborted;
    logic arb_lost;
    logic tx_error;
    logic next_direction;
    logic next_send_request;
    logic next_abort_request;
    logic next_aborted;
    logic next_arb_lost;
    logic next_tx_error;
    logic fifo_reset;
    logic msg_end;

    // ==========================================================
    // Next state
    assign fifo_reset = write_en && wdata[can_filt_pkg::FIFO_RESET_BIT];
    assign msg_end = event_here &&
        (tx_event.completed || tx_event.aborted);

    always_comb begin
        next_direction = direction;
        next_send_request = send_request;
        next_abort_request = abort_request;
        next_aborted = aborted;
        next_arb_lost = arb_lost;
        next_tx_error = tx_error;
        if (write_en && config_mode) begin
            next_direction = wdata[can_filt_pkg::DIR_BIT];
        end
        if (fifo_reset) begin
            next_send_request = 1'b0;
            next_abort_request = 1'b0;
            next_aborted = 1'b0;
            next_arb_lost = 1'b0;
            next_tx_error = 1'b0;
        end
        if (event_here && (tx_event.all_sent || tx_event.aborted)) begin
            next_send_request = 1'b0;
        end
        if (msg_end) begin
            next_abort_request = 1'b0;
        end
        if (write_en && direction && !fifo_reset) begin
            if (wdata[can_filt_pkg::REQ_BIT]) begin
                next_send_request = 1'b1;
            end else if (send_request) begin
                next_abort_request = 1'b1;
            end
        end
        if (msg_end) begin
            next_aborted = tx_event.aborted;
        end
        if (read_en) begin
            next_arb_lost = 1'b0;
            next_tx_error = 1'b0;
        end
        // arbitration loss sets
        // Events beat same-cycle read or reset clears
        if (event_here && tx_event.arb_lost) begin
            next_arb_lost = 1'b1;
        end
        if (event_here && tx_event.bus_err) begin
            next_tx_error = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            direction <= 1'b0;
            send_request <= 1'b0;
            abort_request <= 1'b0;
            aborted <= 1'b0;
            arb_lost <= 1'b0;
            tx_error <= 1'b0;
        end else begin
            direction <= next_direction;
            send_request <= next_send_request;
            abort_request <= next_abort_request;
            aborted <= next_aborted;
            arb_lost <= next_arb_lost;
            tx_error <= next_tx_error;
        end
    end

    // ==========================================================
    // Readback
    always_comb begin
        status = 8'h00;
        status[can_filt_pkg::DIR_BIT] = direction;
        status[can_filt_pkg::ABORT_BIT] = aborted;
        status[can_filt_pkg::ARB_BIT] = arb_lost;
        status[can_filt_pkg::ERR_BIT] = tx_error;
        status[can_filt_pkg::REQ_BIT] = send_request;
    end
endmodule : can_fifo_ctrl
`default_nettype wire

//--- rtl/can_filt_pkg.sv
// Shared constants and carrier types for the CAN acceptance filter block
package can_filt_pkg;
    // ==========================================================
    // Bus and address map
    localparam int ADDR_WIDTH = 8;
    localparam logic [3:0] MASK_REGION = 4'h0;
    localparam logic [3:0] FILTER_ID_REGION = 4'h1;
    localparam logic [7:0] FILTER_CTRL0_ADDR = 8'h20;
    localparam logic [7:0] CONTROLLER_CTRL_ADDR = 8'h24;
    localparam logic [1:0] FIFO_REGION = 2'h1;
    localparam logic [1:0] WORD_ALIGNED = 2'h0;

    // ==========================================================
    // Mask and filter identifier layout
    localparam int SID_MSB = 31;
    localparam int SID_LSB = 21;
    localparam int ID_TYPE_MATCH_ENABLE_BIT = 19;
    localparam int FILTER_EXTENDED_FRAME_FLAG_BIT = 19;
    localparam int EID_MSB = 17;
    localparam int EID_LSB = 0;
    localparam logic [31:0] MASK_USED_BITS = 32'hFFEB_FFFF;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;

    // ==========================================================
    // Controller control and filter control layout
    localparam int OPMODE_MSB = 23;
    localparam int OPMODE_LSB = 21;
    localparam logic [2:0] CONFIG_MODE = 3'h4;
    localparam int FILTER_STRIDE = 8;
    localparam int FSEL_LSB = 0;
    localparam int FSEL_WIDTH = 5;
    localparam int MSEL_LSB = 5;
    localparam int FILTER_EN_BIT = 7;
    localparam logic [23:0] FILTER_CTRL_RESET = 24'h00_0000;

    // ==========================================================
    // FIFO control layout
    localparam int FIFO_RESET_BIT = 14;
    localparam int DIR_BIT = 7;
    localparam int ABORT_BIT = 6;
    localparam int ARB_BIT = 5;
    localparam int ERR_BIT = 4;
    localparam int REQ_BIT = 3;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic ext;
        logic [10:0] standard_id_mask_bits;
        logic [17:0] extended_id_mask_bits;
    } can_id_type;

    typedef struct packed {
        logic valid;
        logic [3:0] fifo;
        logic completed;
        logic aborted;
        logic arb_lost;
        logic bus_err;
        logic all_sent;
    } tx_event_type;

    typedef struct packed {
        logic valid;
        logic [3:0] fifo;
        logic [1:0] filter;
    } rx_route_type;
endpackage : can_filt_pkg

//--- rtl/can_filter_match.sv
// Combinational identifier match for one acceptance filter
`timescale 1ns/1ps
`default_nettype none
module can_filter_match (
    input wire can_filt_pkg::can_id_type msg,
    input wire logic [31:0] filter_id,
    input wire logic [31:0] mask,
    input wire logic enable,
    output logic hit
);
    logic [10:0] sid_diff;
    logic [17:0] eid_diff;
    logic type_ok;

    // ==========================================================
    // Masked compare
    // xor and mask
    assign sid_diff = (msg.standard_id_mask_bits ^
        filter_id[can_filt_pkg::SID_MSB:can_filt_pkg::SID_LSB]) &
        mask[can_filt_pkg::SID_MSB:can_filt_pkg::SID_LSB];
    assign eid_diff = (msg.extended_id_mask_bits ^
        filter_id[can_filt_pkg::EID_MSB:can_filt_pkg::EID_LSB]) &
        mask[can_filt_pkg::EID_MSB:can_filt_pkg::EID_LSB];
    assign type_ok = !mask[can_filt_pkg::ID_TYPE_MATCH_ENABLE_BIT] ||
        (msg.ext == filter_id[can_filt_pkg::FILTER_EXTENDED_FRAME_FLAG_BIT]);
    // disabled never hits
    // Standard frames carry no extended bits to compare
    assign hit = enable && type_ok && (sid_diff == 11'h000) &&
        (!msg.ext || (eid_diff == 18'h0_0000));
endmodule : can_filter_match
`default_nettype wire

//--- sim/can_bus_node.sv
// Behavioural protocol engine and bus traffic source
`timescale 1ns/1ps
`default_nettype none
module can_bus_node (
    input wire logic clk,
    output logic rx_msg_valid,
    output var can_filt_pkg::can_id_type rx_msg,
    output var can_filt_pkg::tx_event_type tx_event
);
    initial begin
        rx_msg_valid = 1'b0;
        rx_msg = '0;
        tx_event = '0;
    end
    task automatic send_msg(input logic [29:0] id);
        @(posedge clk);
        rx_msg_valid <= 1'b1;
        rx_msg <= id;
        @(posedge clk);
        rx_msg_valid <= 1'b0;
        // Scrambled when idle, so stale ids never match
        rx_msg <= ~id;
        #1;
    endtask : send_msg
    task automatic send_event(input logic [3:0] f, input logic [4:0] fl);
        @(posedge clk);
        tx_event <= {1'b1, f, fl};
        @(posedge clk);
        tx_event <= {1'b0, ~f, ~fl};
        #1;
    endtask : send_event
endmodule : can_bus_node
`default_nettype wire

//--- sim/can_filt_asserts.sv
// Port-level assertions for the acceptance filter block
`timescale 1ns/1ps
`default_nettype none
module can_filt_asserts #(
    parameter int NUM_FIFOS = 16,
    parameter int NUM_FILTERS = 3
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_msg_valid,
    input wire can_filt_pkg::tx_event_type tx_event,
    input wire can_filt_pkg::rx_route_type rx_route,
    input wire logic [2:0] operating_mode_field,
    input wire logic [NUM_FIFOS-1:0] fifo_direction,
    input wire logic [NUM_FIFOS-1:0] send_request,
    input wire logic [NUM_FIFOS-1:0] abort_request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    property p_answer;
        s_access |=> s_answer;
    endproperty
    a_answer: assert property (p_answer)
        else $error("pready not a single pulse after access");
    property p_err_data;
        pslverr |-> pready && prdata == 32'h0000_0000;
    endproperty
    a_err_data: assert property (p_err_data)
        else $error("pslverr without pready or with data");
    property p_mode;
        !$stable(operating_mode_field) |-> $past(pready && pwrite);
    endproperty
    a_mode: assert property (p_mode)
        else $error("operating mode changed without a write");
    property p_dir;
        !$stable(fifo_direction) |-> $past(pready && pwrite
            && operating_mode_field == can_filt_pkg::CONFIG_MODE);
    endproperty
    a_dir: assert property (p_dir)
        else $error("fifo direction changed outside config mode");
    property p_route;
        rx_route.valid |-> $past(rx_msg_valid)
            && rx_route.filter < NUM_FILTERS;
    endproperty
    a_route: assert property (p_route)
        else $error("route without a received identifier");
    property p_req_tx;
        (send_request & ~$past(send_request) & ~fifo_direction) == '0;
    endproperty
    a_req_tx: assert property (p_req_tx)
        else $error("send request rose on a receive fifo");
    property p_req_clear;
        ($past(send_request) & ~send_request) != '0
            |-> $past(tx_event.valid || (pready && pwrite));
    endproperty
    a_req_clear: assert property (p_req_clear)
        else $error("send request cleared with no cause");
    property p_abort_rise;
        (abort_request & ~$past(abort_request) & ~$past(send_request)) == '0;
    endproperty
    a_abort_rise: assert property (p_abort_rise)
        else $error("abort request without pending send");
endmodule : can_filt_asserts

bind can_acceptance_filter_fifo_ctrl can_filt_asserts #(
    .NUM_FIFOS(NUM_FIFOS),
    .NUM_FILTERS(NUM_FILTERS)
) u_can_filt_asserts (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_msg_valid(rx_msg_valid),
    .tx_event(tx_event), .rx_route(rx_route),
    .operating_mode_field(operating_mode_field),
    .fifo_direction(fifo_direction), .send_request(send_request),
    .abort_request(abort_request)
);
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the acceptance filter block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_msg_valid;
    can_filt_pkg::can_id_type rx_msg;
    can_filt_pkg::tx_event_type tx_event;
    can_filt_pkg::rx_route_type rx_route;
    logic [2:0] operating_mode_field;
    logic [15:0] fifo_direction;
    logic [15:0] send_request;
    logic [15:0] abort_request;
    logic [31:0] rdata;
    logic err;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    can_acceptance_filter_fifo_ctrl u_can_acceptance_filter_fifo_ctrl (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_msg_valid(rx_msg_valid), .rx_msg(rx_msg),
        .tx_event(tx_event), .rx_route(rx_route),
        .operating_mode_field(operating_mode_field),
        .fifo_direction(fifo_direction), .send_request(send_request),
        .abort_request(abort_request));
    can_bus_node u_can_bus_node (.clk(clk), .rx_msg_valid(rx_msg_valid),
        .rx_msg(rx_msg), .tx_event(tx_event));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    // Hang guard, generous against under two hundred cycles of traffic
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdata, exp);
        chk({31'h0, err}, 32'h0000_0000);
    endtask : rd
    task automatic rx(input logic [29:0] id, input logic [6:0] exp);
        u_can_bus_node.send_msg(id);
        if (exp[6]) chk(32'(rx_route), 32'(exp));
        else chk(32'(rx_route.valid), 32'h0000_0000);
    endtask : rx
    task automatic t_reset();
        rd(8'h00, 32'h0000_0000);
        rd(8'h4C, 32'h0000_0000);
        apb(1'b0, 8'hFC, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        $display("test reset done");
    endtask : t_reset
    task automatic t_masks();
        wr(8'h00, 32'hFFFF_FFFF);
        rd(8'h00, 32'h0000_0000);
        wr(8'h24, 32'h0080_0000);
        chk(32'(operating_mode_field), 32'h0000_0004);
        wr(8'h04, 32'hFFFF_FFFF);
        rd(8'h04, 32'hFFEB_FFFF);
        $display("test masks done");
    endtask : t_masks
    task automatic t_filters();
        wr(8'h10, 32'h2468_0055);
        wr(8'h20, 32'h0000_89A5);
        rx({1'b1, 11'h123, 18'h0_0055}, 7'h54);
        rx({1'b1, 11'h123, 18'h0_0054}, 7'h65);
        rx({1'b1, 11'h124, 18'h0_0055}, 7'h65);
        rx({1'b0, 11'h123, 18'h0_0055}, 7'h65);
        wr(8'h20, 32'h0000_0001);
        rd(8'h20, 32'h0000_0925);
        rx({1'b1, 11'h123, 18'h0_0055}, 7'h00);
        wr(8'h20, 32'h0000_0090);
        rd(8'h20, 32'h0000_0090);
        rx({1'b1, 11'h123, 18'h0_0055}, 7'h00);
        wr(8'h20, 32'h0000_0000);
        wr(8'h20, 32'h0000_008F);
        rx({1'b0, 11'h7FF, 18'h0_0000}, 7'h7C);
        $display("test filters done");
    endtask : t_filters
    task automatic t_fifo();
        wr(8'h4C, 32'h0000_0080);
        rd(8'h4C, 32'h0000_0080);
        chk(32'(fifo_direction), 32'h0000_0008);
        wr(8'h4C, 32'h0000_0088);
        chk(32'(send_request), 32'h0000_0008);
        u_can_bus_node.send_event(4'h3, 5'h04);
        rd(8'h4C, 32'h0000_00A8);
        rd(8'h4C, 32'h0000_0088);
        u_can_bus_node.send_event(4'h3, 5'h02);
        rd(8'h4C, 32'h0000_0098);
        wr(8'h4C, 32'h0000_0080);
        chk(32'(abort_request), 32'h0000_0008);
        u_can_bus_node.send_event(4'h3, 5'h08);
        rd(8'h4C, 32'h0000_00C0);
        chk(32'(abort_request), 32'h0000_0000);
        u_can_bus_node.send_event(4'h3, 5'h04);
        rd(8'h4C, 32'h0000_00E0);
        wr(8'h4C, 32'h0000_4080);
        rd(8'h4C, 32'h0000_0080);
        wr(8'h4C, 32'h0000_0088);
        u_can_bus_node.send_event(4'h3, 5'h11);
        rd(8'h4C, 32'h0000_0080);
        wr(8'h50, 32'h0000_0008);
        chk(32'(send_request), 32'h0000_0000);
        $display("test fifo done");
    endtask : t_fifo
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_masks();
        t_filters();
        t_fifo();
        complete_run();
    end
endmodule : testbench
`default_nettype wire
